//--- core/ubt_top.sv
// Purpose: execution-count break, branch trace queues, channel A ID compare
// Assumes: core signals are synchronous to aclk, match inputs are pulses
// Notes: aresetn is power-on reset, manual_resetn only clears trace flags
//
// Local design decisions: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/10ps

// Notes on behaviour
// - count is 12 bits, top twenty read zero
// - power-on reset loads count with zero
// - counting applies only while count break enabled
// - each channel B match decrements a nonzero count, zero holds
// - break only on match with count one while enabled, on every match while disabled
// - count holds up to 4095
// - capture last fetch before branch, read-only
// - capture sets source valid flag
// - reading source trace clears its valid flag
// - eight source entries shift on each branch
// - resets clear valid flags only
// - bits 30:28 hold decode buffer pointer
// - even pointer is buffer, odd adds two
// - capture first fetch after branch, read-only
// - destination flag set on capture, read clears
// - eight destination entries shift each branch
// - destination bits 30:28 read zero
// - 8-bit ID compare register, not reset
// - single control bit enables count break
// - ID mask bit drops channel A ID
module ubt_top import ubt_pkg::*; #(
    parameter int DEPTH = TRACE_DEPTH
) (
    // clock and resets
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic manual_resetn,
    // register bus
    input wire logic [ADDR_W-1:0] s_axil_awaddr,
    input wire logic s_axil_awvalid,
    output logic s_axil_awready,
    input wire logic [31:0] s_axil_wdata,
    input wire logic [3:0] s_axil_wstrb,
    input wire logic s_axil_wvalid,
    output logic s_axil_wready,
    output logic [1:0] s_axil_bresp,
    output logic s_axil_bvalid,
    input wire logic s_axil_bready,
    input wire logic [ADDR_W-1:0] s_axil_araddr,
    input wire logic s_axil_arvalid,
    output logic s_axil_arready,
    output logic [31:0] s_axil_rdata,
    output logic [1:0] s_axil_rresp,
    output logic s_axil_rvalid,
    input wire logic s_axil_rready,
    // core fetch and branch
    input wire logic branch_taken,
    input wire ubt_branch_s branch_info,
    // channel matches
    input wire logic chan_a_addr_match,
    input wire logic [ADDRESS_SPACE_ID_W-1:0] address_space_id,
    input wire logic chan_b_match,
    // results
    output logic chan_a_match,
    output logic user_break_req,
    output logic [PTR_W-1:0] last_decode_buffer
);
    typedef struct packed {
        logic [COUNT_W-1:0] count;
        logic count_break_enable;
        logic chan_a_id_mask;
        logic [ADDRESS_SPACE_ID_W-1:0] chan_a_space_id_value;
        logic [SEL_W-1:0] trace_sel;
        logic break_req;
        logic a_match;
        logic [PTR_W-1:0] buf_num;
    } ubt_top_s;

    ubt_top_s st_r;
    ubt_top_s st_nxt;

    logic wr_en;
    ubt_reg_wr_s wr;
    logic wr_err;
    logic rd_en;
    logic [ADDR_W-1:0] rd_addr;
    logic [31:0] rd_data;
    logic rd_err;
    logic src_valid;
    logic [FETCH_W+PTR_W-1:0] src_data;
    logic dst_valid;
    logic [FETCH_W-1:0] dst_data;
    logic src_clr;
    logic dst_clr;
    logic [31:0] merged;

    // byte-lane merge of a write into an old word
    function automatic logic [31:0] ubt_merge(
        input logic [31:0] old,
        input logic [31:0] data,
        input logic [3:0] strb
    );
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[b*8 +: 8] = data[b*8 +: 8];
            end
        end
        return res;
    endfunction : ubt_merge

    // buffer number from decode pointer
    function automatic logic [PTR_W-1:0] ubt_buffer_num(input logic [PTR_W-1:0] ptr);
        logic [PTR_W-1:0] res;
        res = ptr[0] ? ptr + 3'h2 : ptr;
        return res;
    endfunction : ubt_buffer_num

    function automatic logic ubt_mapped(input logic [ADDR_W-1:0] a);
        logic ok;
        ok = (a == OFS_EXEC_COUNT) || (a == OFS_SRC_TRACE) || (a == OFS_DST_TRACE)
            || (a == OFS_ADDRESS_SPACE_ID_CMP) || (a == OFS_CONTROL) || (a == OFS_TRACE_SEL);
        return ok;
    endfunction : ubt_mapped

    ubt_axil_slave u_slave (
        .aclk(aclk),
        .aresetn(aresetn),
        .s_axil_awaddr(s_axil_awaddr),
        .s_axil_awvalid(s_axil_awvalid),
        .s_axil_awready(s_axil_awready),
        .s_axil_wdata(s_axil_wdata),
        .s_axil_wstrb(s_axil_wstrb),
        .s_axil_wvalid(s_axil_wvalid),
        .s_axil_wready(s_axil_wready),
        .s_axil_bresp(s_axil_bresp),
        .s_axil_bvalid(s_axil_bvalid),
        .s_axil_bready(s_axil_bready),
        .s_axil_araddr(s_axil_araddr),
        .s_axil_arvalid(s_axil_arvalid),
        .s_axil_arready(s_axil_arready),
        .s_axil_rdata(s_axil_rdata),
        .s_axil_rresp(s_axil_rresp),
        .s_axil_rvalid(s_axil_rvalid),
        .s_axil_rready(s_axil_rready),
        .wr_en(wr_en),
        .wr(wr),
        .wr_err(wr_err),
        .rd_en(rd_en),
        .rd_addr(rd_addr),
        .rd_data(rd_data),
        .rd_err(rd_err)
    );

    assign src_clr = rd_en && (rd_addr == OFS_SRC_TRACE);
    assign dst_clr = rd_en && (rd_addr == OFS_DST_TRACE);

    // source side: last fetch before branch plus decode pointer
    ubt_trace_queue #(
        .DEPTH(DEPTH),
        .WIDTH(FETCH_W + PTR_W)
    ) u_src_queue (
        .aclk(aclk),
        .aresetn(aresetn),
        .manual_resetn(manual_resetn),
        .push(branch_taken),
        .push_data({branch_info.ptr, branch_info.src_addr}),
        .sel(st_r.trace_sel),
        .clr(src_clr),
        .hit_valid(src_valid),
        .hit_data(src_data)
    );

    // destination side: first fetch after branch
    ubt_trace_queue #(
        .DEPTH(DEPTH),
        .WIDTH(FETCH_W)
    ) u_dst_queue (
        .aclk(aclk),
        .aresetn(aresetn),
        .manual_resetn(manual_resetn),
        .push(branch_taken),
        .push_data(branch_info.dst_addr),
        .sel(st_r.trace_sel),
        .clr(dst_clr),
        .hit_valid(dst_valid),
        .hit_data(dst_data)
    );

    // read decode
    always_comb begin
        rd_data = 32'h0000_0000;
        rd_err = 1'b0;
        unique case (rd_addr)
            OFS_EXEC_COUNT: rd_data[COUNT_W-1:0] = st_r.count;
            OFS_SRC_TRACE: begin
                rd_data[VALID_BIT] = src_valid;
                rd_data[PTR_LSB+PTR_W-1:0] = src_data;
            end
            OFS_DST_TRACE: begin
                rd_data[VALID_BIT] = dst_valid;
                rd_data[FETCH_W-1:0] = dst_data;
            end
            OFS_ADDRESS_SPACE_ID_CMP: rd_data[ADDRESS_SPACE_ID_W-1:0] = st_r.chan_a_space_id_value;
            OFS_CONTROL: begin
                rd_data[CTRL_COUNT_EN_BIT] = st_r.count_break_enable;
                rd_data[CTRL_ID_MASK_BIT] = st_r.chan_a_id_mask;
            end
            OFS_TRACE_SEL: rd_data[SEL_W-1:0] = st_r.trace_sel;
            default: rd_err = 1'b1;
        endcase
    end

    // trace registers are read-only, a write there is refused
    assign wr_err = !ubt_mapped(wr.addr) || (wr.addr == OFS_SRC_TRACE)
        || (wr.addr == OFS_DST_TRACE);

    always_comb begin
        merged = 32'h0000_0000;
        st_nxt = st_r;
        st_nxt.break_req = 1'b0;
        // channel A ID compare unless masked
        st_nxt.a_match = chan_a_addr_match && (st_r.chan_a_id_mask
            || (address_space_id == st_r.chan_a_space_id_value));
        if (branch_taken) begin
            st_nxt.buf_num = ubt_buffer_num(branch_info.ptr);
        end
        if (chan_b_match) begin
            if (!st_r.count_break_enable) begin
                st_nxt.break_req = 1'b1;
            end else if (st_r.count != COUNT_RST) begin
                st_nxt.count = st_r.count - COUNT_ONE;
                st_nxt.break_req = (st_r.count == COUNT_ONE);
            end
        end
        if (wr_en && !wr_err) begin
            unique case (wr.addr)
                OFS_EXEC_COUNT: begin
                    merged = ubt_merge({20'h0_0000, st_r.count}, wr.data, wr.strb);
                    st_nxt.count = merged[COUNT_W-1:0];
                end
                OFS_ADDRESS_SPACE_ID_CMP: begin
                    merged = ubt_merge({24'h00_0000, st_r.chan_a_space_id_value},
                        wr.data, wr.strb);
                    st_nxt.chan_a_space_id_value = merged[ADDRESS_SPACE_ID_W-1:0];
                end
                OFS_CONTROL: begin
                    merged = ubt_merge(32'h0000_0000, wr.data, wr.strb);
                    if (wr.strb[0]) begin
                        st_nxt.count_break_enable = merged[CTRL_COUNT_EN_BIT];
                    end
                    if (wr.strb[2]) begin
                        st_nxt.chan_a_id_mask = merged[CTRL_ID_MASK_BIT];
                    end
                end
                OFS_TRACE_SEL: begin
                    if (wr.strb[0]) begin
                        st_nxt.trace_sel = wr.data[SEL_W-1:0];
                    end
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r <= '0;
            st_r.count <= COUNT_RST;
            st_r.trace_sel <= SEL_RST;
            st_r.chan_a_space_id_value <= st_nxt.chan_a_space_id_value;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign chan_a_match = st_r.a_match;
    assign user_break_req = st_r.break_req;
    assign last_decode_buffer = st_r.buf_num;
endmodule : ubt_top

//--- core/ubt_pkg.sv
// Purpose: shared constants and carriers for break count and branch trace
// Assumes: 32-bit AXI4-Lite register access, one word per register
// Notes: offsets are byte addresses
package ubt_pkg;
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] OFS_EXEC_COUNT = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_SRC_TRACE = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_DST_TRACE = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_ADDRESS_SPACE_ID_CMP = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_CONTROL = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_TRACE_SEL = 8'h14;

    localparam int COUNT_W = 12;
    localparam logic [COUNT_W-1:0] COUNT_RST = 12'h000;
    localparam logic [COUNT_W-1:0] COUNT_ONE = 12'h001;
    localparam int CTRL_COUNT_EN_BIT = 0;
    localparam int CTRL_ID_MASK_BIT = 21;
    localparam int VALID_BIT = 31;
    localparam int PTR_LSB = 28;
    localparam int PTR_W = 3;
    localparam int FETCH_W = 28;
    localparam int ADDRESS_SPACE_ID_W = 8;
    localparam int TRACE_DEPTH = 8;
    localparam int SEL_W = 3;
    localparam logic [SEL_W-1:0] SEL_RST = 3'h0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [FETCH_W-1:0] src_addr;
        logic [PTR_W-1:0] ptr;
        logic [FETCH_W-1:0] dst_addr;
    } ubt_branch_s;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [31:0] data;
        logic [3:0] strb;
    } ubt_reg_wr_s;
endpackage : ubt_pkg

//--- core/ubt_trace_queue.sv
// Purpose: eight-deep shift queue of trace entries with per-entry valid
// Assumes: push shifts every entry down by one, newest at index 0
// Notes: only valid flags are reset, payload keeps its contents
`timescale 1ns/10ps
module ubt_trace_queue import ubt_pkg::*; #(
    parameter int DEPTH = TRACE_DEPTH,
    parameter int WIDTH = 31
) (
    // clock and resets
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic manual_resetn,
    // capture side
    input wire logic push,
    input wire logic [WIDTH-1:0] push_data,
    // software view
    input wire logic [SEL_W-1:0] sel,
    input wire logic clr,
    output logic hit_valid,
    output logic [WIDTH-1:0] hit_data
);
    typedef struct packed {
        logic [DEPTH-1:0] valid;
        logic [DEPTH-1:0][WIDTH-1:0] data;
    } ubt_queue_s;

    ubt_queue_s st_r;
    ubt_queue_s st_nxt;

    always_comb begin
        int k;
        k = 0;
        st_nxt = st_r;
        if (push) begin
            for (int i = DEPTH - 1; i > 0; i--) begin
                st_nxt.data[i] = st_r.data[i-1];
                st_nxt.valid[i] = st_r.valid[i-1];
            end
            st_nxt.data[0] = push_data;
            st_nxt.valid[0] = 1'b1;
        end
        // read entry follows the shift, so a new capture is never cleared
        if (clr) begin
            k = int'(sel) + (push ? 1 : 0);
            if (k < DEPTH) begin
                st_nxt.valid[k] = 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || !manual_resetn) begin
            st_r.valid <= '0;
            st_r.data <= st_nxt.data;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign hit_valid = st_r.valid[sel];
    assign hit_data = st_r.data[sel];
endmodule : ubt_trace_queue

//--- core/ubt_axil_slave.sv
// Purpose: AXI4-Lite slave front end, one write and one read at a time
// Assumes: decode and side effects live in the parent
// Notes: read side effect fires on the address handshake
`timescale 1ns/10ps
module ubt_axil_slave import ubt_pkg::*; (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // write address and data
    input wire logic [ADDR_W-1:0] s_axil_awaddr,
    input wire logic s_axil_awvalid,
    output logic s_axil_awready,
    input wire logic [31:0] s_axil_wdata,
    input wire logic [3:0] s_axil_wstrb,
    input wire logic s_axil_wvalid,
    output logic s_axil_wready,
    // write response
    output logic [1:0] s_axil_bresp,
    output logic s_axil_bvalid,
    input wire logic s_axil_bready,
    // read address and data
    input wire logic [ADDR_W-1:0] s_axil_araddr,
    input wire logic s_axil_arvalid,
    output logic s_axil_arready,
    output logic [31:0] s_axil_rdata,
    output logic [1:0] s_axil_rresp,
    output logic s_axil_rvalid,
    input wire logic s_axil_rready,
    // register side
    output logic wr_en,
    output ubt_reg_wr_s wr,
    input wire logic wr_err,
    output logic rd_en,
    output logic [ADDR_W-1:0] rd_addr,
    input wire logic [31:0] rd_data,
    input wire logic rd_err
);
    typedef struct packed {
        logic aw_rdy;
        logic w_rdy;
        logic aw_have;
        logic w_have;
        ubt_reg_wr_s wr;
        logic bvalid;
        logic [1:0] bresp;
        logic ar_rdy;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } ubt_slave_s;

    ubt_slave_s st_r;
    ubt_slave_s st_nxt;

    assign wr_en = st_r.aw_have & st_r.w_have & ~st_r.bvalid;
    assign wr = st_r.wr;
    assign rd_en = s_axil_arvalid & st_r.ar_rdy;
    assign rd_addr = s_axil_araddr;

    always_comb begin
        st_nxt = st_r;
        if (s_axil_awvalid && st_r.aw_rdy) begin
            st_nxt.aw_have = 1'b1;
            st_nxt.aw_rdy = 1'b0;
            st_nxt.wr.addr = s_axil_awaddr;
        end
        if (s_axil_wvalid && st_r.w_rdy) begin
            st_nxt.w_have = 1'b1;
            st_nxt.w_rdy = 1'b0;
            st_nxt.wr.data = s_axil_wdata;
            st_nxt.wr.strb = s_axil_wstrb;
        end
        if (wr_en) begin
            st_nxt.aw_have = 1'b0;
            st_nxt.w_have = 1'b0;
            st_nxt.bvalid = 1'b1;
            st_nxt.bresp = wr_err ? RESP_SLVERR : RESP_OKAY;
        end
        if (st_r.bvalid && s_axil_bready) begin
            st_nxt.bvalid = 1'b0;
            st_nxt.aw_rdy = 1'b1;
            st_nxt.w_rdy = 1'b1;
        end
        if (rd_en) begin
            st_nxt.ar_rdy = 1'b0;
            st_nxt.rvalid = 1'b1;
            st_nxt.rdata = rd_data;
            st_nxt.rresp = rd_err ? RESP_SLVERR : RESP_OKAY;
        end
        if (st_r.rvalid && s_axil_rready) begin
            st_nxt.rvalid = 1'b0;
            st_nxt.ar_rdy = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r <= '0;
            st_r.aw_rdy <= 1'b1;
            st_r.w_rdy <= 1'b1;
            st_r.ar_rdy <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign s_axil_awready = st_r.aw_rdy;
    assign s_axil_wready = st_r.w_rdy;
    assign s_axil_bvalid = st_r.bvalid;
    assign s_axil_bresp = st_r.bresp;
    assign s_axil_arready = st_r.ar_rdy;
    assign s_axil_rvalid = st_r.rvalid;
    assign s_axil_rdata = st_r.rdata;
    assign s_axil_rresp = st_r.rresp;
endmodule : ubt_axil_slave

//--- verification/ubt_top_properties.sv
// Purpose: port-level checks for ubt_top
// Assumes: one clock, aresetn synchronous active low
// Notes: bound into every ubt_top instance
`timescale 1ns/10ps
module ubt_top_properties import ubt_pkg::*; (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // register bus
    input wire logic [ADDR_W-1:0] s_axil_awaddr,
    input wire logic s_axil_awvalid,
    input wire logic s_axil_awready,
    input wire logic [1:0] s_axil_bresp,
    input wire logic s_axil_bvalid,
    input wire logic [ADDR_W-1:0] s_axil_araddr,
    input wire logic s_axil_arvalid,
    input wire logic s_axil_arready,
    input wire logic [31:0] s_axil_rdata,
    input wire logic [1:0] s_axil_rresp,
    input wire logic s_axil_rvalid,
    input wire logic s_axil_rready,
    // core side
    input wire logic branch_taken,
    input wire ubt_branch_s branch_info,
    input wire logic chan_a_addr_match,
    input wire logic chan_b_match,
    input wire logic chan_a_match,
    input wire logic user_break_req,
    input wire logic [PTR_W-1:0] last_decode_buffer
);
    logic [ADDR_W-1:0] rd_addr_r;
    logic [ADDR_W-1:0] wr_addr_r;
    // address of the pending answer
    always_ff @(posedge aclk) begin
        if (s_axil_arvalid && s_axil_arready) begin
            rd_addr_r <= s_axil_araddr;
        end
        if (s_axil_awvalid && s_axil_awready) begin
            wr_addr_r <= s_axil_awaddr;
        end
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_break_cause;
        user_break_req |-> $past(chan_b_match);
    endproperty
    a_break_cause: assert property (p_break_cause) else $error("break without match");
    property p_chan_a;
        chan_a_match |-> $past(chan_a_addr_match);
    endproperty
    a_chan_a: assert property (p_chan_a) else $error("channel A hit without address");
    property p_decode;
        branch_taken |=> last_decode_buffer == ($past(branch_info.ptr[0]) ?
            $past(branch_info.ptr) + 3'h2 : $past(branch_info.ptr));
    endproperty
    a_decode: assert property (p_decode) else $error("decode buffer wrong");
    property p_count_top;
        s_axil_rvalid && rd_addr_r == OFS_EXEC_COUNT |-> s_axil_rdata[31:COUNT_W] == '0;
    endproperty
    a_count_top: assert property (p_count_top) else $error("count upper bits set");
    property p_dst_zero;
        s_axil_rvalid && rd_addr_r == OFS_DST_TRACE |-> s_axil_rdata[30:28] == 3'h0;
    endproperty
    a_dst_zero: assert property (p_dst_zero) else $error("destination bits 30:28 set");
    property p_ro_write;
        s_axil_bvalid && (wr_addr_r == OFS_SRC_TRACE || wr_addr_r == OFS_DST_TRACE)
            |-> s_axil_bresp == RESP_SLVERR;
    endproperty
    a_ro_write: assert property (p_ro_write) else $error("trace write accepted");
    property p_unmapped;
        s_axil_rvalid && rd_addr_r >= 8'h18 |-> s_axil_rresp == RESP_SLVERR && s_axil_rdata == '0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
    property p_ar_answer;
        s_axil_arvalid && s_axil_arready |=> s_axil_rvalid && !s_axil_arready;
    endproperty
    a_ar_answer: assert property (p_ar_answer) else $error("read answer late");
    property p_r_hold;
        s_axil_rvalid && !s_axil_rready |=> s_axil_rvalid && $stable(s_axil_rdata);
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("read data dropped");
endmodule : ubt_top_properties

bind ubt_top ubt_top_properties ubt_top_properties_inst (.*);

//--- verification/ubt_core_model.sv
// Purpose: stand-in for the fetch pipeline and interrupt controller
// Assumes: driven from the bench through its tasks
// Notes: released payload shows the inverse of its last value
`timescale 1ns/10ps
module ubt_core_model import ubt_pkg::*; (
    // clock
    input wire logic aclk,
    // core drive
    output logic branch_taken,
    output ubt_branch_s branch_info,
    output logic chan_a_addr_match,
    output logic [ADDRESS_SPACE_ID_W-1:0] address_space_id,
    output logic chan_b_match,
    // break side
    input wire logic chan_a_match,
    input wire logic user_break_req
);
    int break_cnt = 0;
    initial begin
        branch_taken = 1'b0;
        branch_info = '0;
        chan_a_addr_match = 1'b0;
        address_space_id = 8'h00;
        chan_b_match = 1'b0;
    end
    // interrupt controller takes each request pulse
    always @(posedge aclk) begin
        if (user_break_req === 1'b1) begin
            break_cnt <= break_cnt + 1;
        end
    end
    task automatic do_branch(input logic [FETCH_W-1:0] src, input logic [PTR_W-1:0] ptr,
                             input logic [FETCH_W-1:0] dst);
        @(posedge aclk);
        branch_taken <= 1'b1;
        branch_info <= '{src_addr: src, ptr: ptr, dst_addr: dst};
        @(posedge aclk);
        branch_taken <= 1'b0;
        branch_info <= ~branch_info;
    endtask : do_branch
    task automatic b_match();
        @(posedge aclk);
        chan_b_match <= 1'b1;
        @(posedge aclk);
        chan_b_match <= 1'b0;
        @(posedge aclk);
        #1;
    endtask : b_match
    task automatic a_match(input logic [ADDRESS_SPACE_ID_W-1:0] id, output logic hit);
        @(posedge aclk);
        chan_a_addr_match <= 1'b1;
        address_space_id <= id;
        @(posedge aclk);
        chan_a_addr_match <= 1'b0;
        address_space_id <= ~id;
        #1 hit = chan_a_match;
    endtask : a_match
endmodule : ubt_core_model

//--- verification/ubt_top_test.sv
// Purpose: register-level bench for ubt_top
// Assumes: AXI4-Lite master tasks, core stand-in model
// Notes: trace entries selected through the trace select register
`timescale 1ns/10ps
module ubt_top_test import ubt_pkg::*; ;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic manual_resetn = 1'b1;
    logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata;
    logic [3:0] wstrb = 4'hf;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, h;
    logic [1:0] bresp, rresp;
    logic branch_taken, chan_a_addr_match, chan_b_match, chan_a_match, user_break_req;
    ubt_branch_s branch_info;
    logic [ADDRESS_SPACE_ID_W-1:0] address_space_id;
    logic [PTR_W-1:0] last_decode_buffer;
    int fails = 0, tests_run = 0, cycles = 0;

    always #2 aclk = ~aclk;

    ubt_top ubt_top_inst (
        .*, .s_axil_awaddr(awaddr), .s_axil_awvalid(awvalid), .s_axil_awready(awready),
        .s_axil_wdata(wdata), .s_axil_wstrb(wstrb), .s_axil_wvalid(wvalid),
        .s_axil_wready(wready), .s_axil_bresp(bresp), .s_axil_bvalid(bvalid),
        .s_axil_bready(bready), .s_axil_araddr(araddr), .s_axil_arvalid(arvalid),
        .s_axil_arready(arready), .s_axil_rdata(rdata), .s_axil_rresp(rresp),
        .s_axil_rvalid(rvalid), .s_axil_rready(rready));
    ubt_core_model ubt_core_model_inst (.*);

    task automatic results();
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : results
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
        tests_run++;
        if ((got & m) !== (exp & m)) begin
            fails++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: response %h want %h", $time, got, exp);
        end
    endtask : chk_resp
    task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk_resp(bresp, er);
    endtask : axw
    task automatic axr(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
                       input logic [1:0] er);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rready <= 1'b0;
        chk(rdata, e, m);
        chk_resp(rresp, er);
    endtask : axr
    task automatic chk_breaks(input int n);
        chk(32'(ubt_core_model_inst.break_cnt), 32'(n), '1);
    endtask : chk_breaks

    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fails++;
            results();
        end
    end

    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        axr(OFS_EXEC_COUNT, 32'h0000_0000, '1, RESP_OKAY);
        axr(OFS_SRC_TRACE, 32'h0000_0000, 32'h8000_0000, RESP_OKAY);
        axr(OFS_DST_TRACE, 32'h0000_0000, 32'h8000_0000, RESP_OKAY);
        $display("test reset values done");
        axw(OFS_CONTROL, 32'h0000_0001, RESP_OKAY);
        axw(OFS_EXEC_COUNT, 32'hFFFF_FFFF, RESP_OKAY);
        axr(OFS_EXEC_COUNT, 32'h0000_0FFF, '1, RESP_OKAY);
        axw(OFS_EXEC_COUNT, 32'h0000_0003, RESP_OKAY);
        for (int i = 3; i > 0; i--) begin
            ubt_core_model_inst.b_match();
            chk_breaks(i == 1 ? 1 : 0);
            axr(OFS_EXEC_COUNT, 32'(i - 1), '1, RESP_OKAY);
        end
        ubt_core_model_inst.b_match();
        chk_breaks(1);
        axr(OFS_EXEC_COUNT, 32'h0000_0000, '1, RESP_OKAY);
        axw(OFS_CONTROL, 32'h0000_0000, RESP_OKAY);
        axw(OFS_EXEC_COUNT, 32'h0000_0005, RESP_OKAY);
        ubt_core_model_inst.b_match();
        chk_breaks(2);
        axr(OFS_EXEC_COUNT, 32'h0000_0005, '1, RESP_OKAY);
        $display("test execution count done");
        for (int i = 0; i < 9; i++) begin
            ubt_core_model_inst.do_branch(28'h0A5_0000 + 28'(i), 3'(i), 28'h5A0_0000 + 28'(i));
        end
        for (int k = 0; k < 8; k++) begin
            axw(OFS_TRACE_SEL, 32'(k), RESP_OKAY);
            axr(OFS_SRC_TRACE, {1'b1, 3'(8 - k), 28'h0A5_0000 + 28'(8 - k)}, '1, RESP_OKAY);
            axr(OFS_SRC_TRACE, 32'h0000_0000, 32'h8000_0000, RESP_OKAY);
            axr(OFS_DST_TRACE, {4'h8, 28'h5A0_0000 + 28'(8 - k)}, '1, RESP_OKAY);
            axr(OFS_DST_TRACE, 32'h0000_0000, 32'h8000_0000, RESP_OKAY);
        end
        axw(OFS_SRC_TRACE, 32'hFFFF_FFFF, RESP_SLVERR);
        axw(OFS_DST_TRACE, 32'hFFFF_FFFF, RESP_SLVERR);
        axr(8'h20, 32'h0000_0000, '1, RESP_SLVERR);
        $display("test branch trace done");
        ubt_core_model_inst.do_branch(28'h123_4567, 3'h5, 28'h765_4321);
        axw(OFS_TRACE_SEL, 32'h0000_0000, RESP_OKAY);
        axw(OFS_ADDRESS_SPACE_ID_CMP, 32'h0000_00A5, RESP_OKAY);
        @(posedge aclk);
        manual_resetn <= 1'b0;
        @(posedge aclk);
        manual_resetn <= 1'b1;
        axr(OFS_SRC_TRACE, {4'h5, 28'h123_4567}, '1, RESP_OKAY);
        axr(OFS_EXEC_COUNT, 32'h0000_0005, '1, RESP_OKAY);
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        axr(OFS_ADDRESS_SPACE_ID_CMP, 32'h0000_00A5, '1, RESP_OKAY);
        axr(OFS_EXEC_COUNT, 32'h0000_0000, '1, RESP_OKAY);
        axr(OFS_DST_TRACE, 32'h0000_0000, 32'h8000_0000, RESP_OKAY);
        $display("test resets done");
        ubt_core_model_inst.a_match(8'hA5, h);
        chk(32'(h), 32'h0000_0001, '1);
        ubt_core_model_inst.a_match(8'h5A, h);
        chk(32'(h), 32'h0000_0000, '1);
        axw(OFS_CONTROL, 32'h0020_0000, RESP_OKAY);
        ubt_core_model_inst.a_match(8'h5A, h);
        chk(32'(h), 32'h0000_0001, '1);
        $display("test channel A done");
        results();
    end
endmodule : ubt_top_test
